// ---- hdl/gpf_defines.svh ----
`ifndef GPF_DEFINES_SVH
`define GPF_DEFINES_SVH

// Register indices; byte address is four times the index
`define GPF_DATA_IDX 32'hFFFFF74E
`define GPF_DIR_IDX 32'hFFFFF74F
`define GPF_CTRL_IDX 32'hFFFFF750
`define GPF_STAT_IDX 32'hFFFFF751

// Reset values
`define GPF_DATA_RST 16'h0000
`define GPF_DIR_RST 16'h0000
`define GPF_CTRL_RST 16'h0000

// Control register fields
`define GPF_CTRL_ADDRSEL_LSB 0
`define GPF_CTRL_PODSEL 6

// Pin positions of the expansion functions
`define GPF_PIN_BUS_REQUEST_IN 15
`define GPF_PIN_WAIT 8
`define GPF_PIN_POD 5
`define GPF_POD_GATED 5

// Mode strap codes
`define GPF_STRAP_ROM_DIS 2'h0
`define GPF_STRAP_ROM_EN 2'h1

// Timing counts in cycles
`define GPF_ACCESS_CYCLES 3'h4
`define GPF_STRAP_SETTLE 3'h4

// Bus responses
`define GPF_RESP_OKAY 2'h0
`define GPF_RESP_SLVERR 2'h2

`endif

// ---- hdl/gpf_pkg.sv ----
package gpf_pkg;

    // Operating modes of the port
    typedef enum logic [2:0] {
        GPF_MODE_ROM_DIS = 3'b001,
        GPF_MODE_ROM_EN = 3'b010,
        GPF_MODE_SINGLE = 3'b100
    } gpf_mode_t;

    // Role a pin plays in the current mode
    typedef enum logic [2:0] {
        GPF_ROLE_GPIO = 3'b001,
        GPF_ROLE_FOUT = 3'b010,
        GPF_ROLE_FIN = 3'b100
    } gpf_role_t;

    // Bus channel progress
    typedef enum logic [2:0] {
        GPF_BUS_IDLE = 3'b001,
        GPF_BUS_WAIT = 3'b010,
        GPF_BUS_RESP = 3'b100
    } gpf_bus_t;

endpackage

// ---- hdl/gpf_sync.sv ----
`timescale 1ns/10ps
// Three-stage synchroniser; a bit changes once stages two and three agree
module gpf_sync #(
    parameter int WIDTH = 16
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // Shift chain; stage1 only feeds stage2 to keep metastability contained
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= asyncIn;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Per-bit agreement filter
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    syncOut[i] <= 1'b0;
                end else if (stage2[i] == stage3[i]) begin
                    syncOut[i] <= stage3[i];
                end
            end
        end
    endgenerate
endmodule

// ---- hdl/gpf_port.sv ----
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "gpf_defines.svh"

// Overview of operation
// - Pin n maps one to one onto data bit n, for all sixteen pins.
// - With ROM disabled, pins 15..6 are general I/O and pins 5..0 drive address bits 21..16.
// - ROM enabled, pins 15..6 carry the bus control lines in order; pins 5..0 are I/O or address, or pin 5 the disable input.
// - A general output with direction 1 drives the written bit and reads back the stored bit.
// - A general input with direction 0 reads back the live pin level.
// - Writing a general input only updates the stored bit.
// - Direction 1 on a non-output function reads the stored bit and writes leave the pin alone.
// - Direction 0 on a non-input function still reads the pin level and writes only store.
// - Output-disable low floats general outputs on pins 0..4 only.
// - Output-disable high lets pins 0..4 drive their latest written value.
// - Data clears on power-on reset and hardware standby, not on watchdog reset.
// - Software standby and sleep leave the data untouched.
// - Byte and halfword accesses are taken and each completes in four cycles.
module gpf_port #(
    parameter int ADDR_W = 12
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic wdtReset,
    input wire logic [1:0] modePins,
    input wire logic hwStandby,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic busAck,
    input wire logic chipSelect0,
    input wire logic chipSelect1,
    input wire logic chipSelect2,
    input wire logic chipSelect3,
    input wire logic readStrobe,
    input wire logic writeStrobeHigh,
    input wire logic writeStrobeLow,
    input wire logic [21:16] extAddr,
    output logic busRequestIn,
    output logic waitIn,
    output logic outputDisableN,
    input wire logic [15:0] pinIn,
    output logic [15:0] pinOut,
    output logic [15:0] pinOeN,
    output gpf_pkg::gpf_mode_t opMode
);
    import gpf_pkg::*;

    localparam int WA = ADDR_W - 2;
    localparam logic [31:0] DATA_IDX = `GPF_DATA_IDX;
    localparam logic [31:0] DIR_IDX = `GPF_DIR_IDX;
    localparam logic [31:0] CTRL_IDX = `GPF_CTRL_IDX;
    localparam logic [31:0] STAT_IDX = `GPF_STAT_IDX;

    logic [15:0] portFPinData, portFDirection, portFControl, pinSync;
    logic [15:0] readView, funcVal, next_pinOut, next_pinOeN;
    logic [1:0] strapSync;
    logic [2:0] lockCnt, wrCnt, rdCnt;
    logic standbySync, modeLocked, podLevelN, awHave, wHave, wrCommit;
    gpf_bus_t wrState, rdState;
    logic [WA-1:0] wrIdx, rdIdx;
    logic [31:0] wrData;
    logic [3:0] wrStrb;

    // Board-side levels pass through the three-stage synchroniser
    gpf_sync #(.WIDTH(19)) u_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .asyncIn({modePins, hwStandby, pinIn}),
        .syncOut({strapSync, standbySync, pinSync})
    );

    // Role of pin n in the given mode
    function automatic gpf_role_t pinRole(input gpf_mode_t mode, input int n,
                                          input logic [15:0] ctrl);
        gpf_role_t role;
        role = GPF_ROLE_GPIO;
        if (mode != GPF_MODE_ROM_DIS && n == `GPF_PIN_POD && ctrl[`GPF_CTRL_PODSEL]) begin
            role = GPF_ROLE_FIN;
        end else if (mode == GPF_MODE_ROM_DIS && n < 6) begin
            role = GPF_ROLE_FOUT;
        end else if (mode == GPF_MODE_ROM_EN && (n == `GPF_PIN_BUS_REQUEST_IN || n == `GPF_PIN_WAIT)) begin
            role = GPF_ROLE_FIN;
        end else if (mode == GPF_MODE_ROM_EN && (n >= 6 || ctrl[`GPF_CTRL_ADDRSEL_LSB + n])) begin
            role = GPF_ROLE_FOUT;
        end
        return role;
    endfunction

    // Decode of a strapped mode code
    function automatic gpf_mode_t strapMode(input logic [1:0] code);
        gpf_mode_t mode;
        unique case (code)
            `GPF_STRAP_ROM_DIS: mode = GPF_MODE_ROM_DIS;
            `GPF_STRAP_ROM_EN: mode = GPF_MODE_ROM_EN;
            default: mode = GPF_MODE_SINGLE;
        endcase
        return mode;
    endfunction

    // Byte-lane merge of a write into a 16-bit register
    function automatic logic [15:0] laneMerge(input logic [15:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction

    // Mode strap is caught after release, once the synchroniser has settled
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lockCnt <= 3'h0;
            modeLocked <= 1'b0;
            opMode <= GPF_MODE_SINGLE;
        end else if (!modeLocked) begin
            lockCnt <= lockCnt + 3'h1;
            if (lockCnt == `GPF_STRAP_SETTLE) begin
                modeLocked <= 1'b1;
                opMode <= strapMode(strapSync);
            end
        end
    end

    // Output-disable level; idle high when pin 5 is not the disable input
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            podLevelN <= 1'b1;
        end else begin
            podLevelN <= (opMode != GPF_MODE_ROM_DIS && portFControl[`GPF_CTRL_PODSEL]) ?
                         pinSync[`GPF_PIN_POD] : 1'b1;
        end
    end

    // Levels handed to the bus controller and the rest of the chip
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busRequestIn <= 1'b0;
            waitIn <= 1'b0;
            outputDisableN <= 1'b1;
        end else begin
            busRequestIn <= (opMode == GPF_MODE_ROM_EN) && pinSync[`GPF_PIN_BUS_REQUEST_IN];
            waitIn <= (opMode == GPF_MODE_ROM_EN) && pinSync[`GPF_PIN_WAIT];
            outputDisableN <= podLevelN;
        end
    end

    // Function values in pin order; zeros stand at the input-only pins
    assign funcVal = {1'b0, busAck, chipSelect3, chipSelect2, chipSelect1, chipSelect0,
                      readStrobe, 1'b0, writeStrobeHigh, writeStrobeLow, extAddr};

    // Per-pin read view and drive
    genvar n;
    generate
        for (n = 0; n < 16; n++) begin : g_pin
            // Direction alone picks stored bit or pin level, whatever the role
            assign readView[n] = portFDirection[n] ? portFPinData[n] : pinSync[n];

            always_comb begin
                next_pinOut[n] = 1'b0;
                next_pinOeN[n] = 1'b1;
                unique case (pinRole(opMode, n, portFControl))
                    GPF_ROLE_GPIO: begin
                        next_pinOut[n] = portFPinData[n];
                        if (portFDirection[n] && !(n < `GPF_POD_GATED && !podLevelN)) begin
                            next_pinOeN[n] = 1'b0;
                        end
                    end
                    GPF_ROLE_FOUT: begin
                        next_pinOut[n] = funcVal[n];
                        next_pinOeN[n] = 1'b0;
                    end
                    default: begin
                        next_pinOeN[n] = 1'b1;
                    end
                endcase
            end
        end
    endgenerate

    // Pin drivers float until the mode is known and during hardware standby
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pinOut <= 16'h0000;
            pinOeN <= 16'hFFFF;
        end else if (!modeLocked || standbySync) begin
            pinOut <= 16'h0000;
            pinOeN <= 16'hFFFF;
        end else begin
            pinOut <= next_pinOut;
            pinOeN <= next_pinOeN;
        end
    end

    // Write address and data may arrive in either order
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            awready <= 1'b0;
            wready <= 1'b0;
            awHave <= 1'b0;
            wHave <= 1'b0;
            wrIdx <= '0;
            wrData <= 32'h00000000;
            wrStrb <= 4'h0;
        end else if (wrState == GPF_BUS_RESP) begin
            if (bready) begin
                awready <= 1'b1;
                wready <= 1'b1;
                awHave <= 1'b0;
                wHave <= 1'b0;
            end
        end else begin
            if (!awHave && !awready) begin
                awready <= 1'b1;
            end
            if (!wHave && !wready) begin
                wready <= 1'b1;
            end
            if (awvalid && awready) begin
                awHave <= 1'b1;
                awready <= 1'b0;
                wrIdx <= awaddr[ADDR_W-1:2];
            end
            if (wvalid && wready) begin
                wHave <= 1'b1;
                wready <= 1'b0;
                wrData <= wdata;
                wrStrb <= wstrb;
            end
        end
    end

    // Write latency: answer four edges after the later of address and data
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wrState <= GPF_BUS_IDLE;
            wrCnt <= 3'h0;
            bvalid <= 1'b0;
            bresp <= `GPF_RESP_OKAY;
        end else begin
            unique case (wrState)
                GPF_BUS_IDLE: begin
                    if (awHave && wHave) begin
                        wrState <= GPF_BUS_WAIT;
                        wrCnt <= 3'h0;
                    end
                end
                GPF_BUS_WAIT: begin
                    wrCnt <= wrCnt + 3'h1;
                    if (wrCnt == `GPF_ACCESS_CYCLES - 3'h3) begin
                        wrState <= GPF_BUS_RESP;
                        bvalid <= 1'b1;
                        bresp <= (wrIdx == DATA_IDX[WA-1:0] || wrIdx == DIR_IDX[WA-1:0] ||
                                  wrIdx == CTRL_IDX[WA-1:0] || wrIdx == STAT_IDX[WA-1:0]) ?
                                 `GPF_RESP_OKAY : `GPF_RESP_SLVERR;
                    end
                end
                GPF_BUS_RESP: begin
                    if (bready) begin
                        wrState <= GPF_BUS_IDLE;
                        bvalid <= 1'b0;
                    end
                end
            endcase
        end
    end

    assign wrCommit = (wrState == GPF_BUS_WAIT) && (wrCnt == `GPF_ACCESS_CYCLES - 3'h3);

    // Data register: only power-on reset and hardware standby clear it
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            portFPinData <= `GPF_DATA_RST;
        end else if (standbySync) begin
            portFPinData <= `GPF_DATA_RST;
        end else if (wrCommit && wrIdx == DATA_IDX[WA-1:0]) begin
            // Stored whatever the pin role; the drive logic decides the pin
            portFPinData <= laneMerge(portFPinData, wrData, wrStrb);
        end
        // No sleep or software standby term, so contents are held
    end

    // Direction and control also return to reset on a watchdog reset
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            portFDirection <= `GPF_DIR_RST;
            portFControl <= `GPF_CTRL_RST;
        end else if (wdtReset || standbySync) begin
            portFDirection <= `GPF_DIR_RST;
            portFControl <= `GPF_CTRL_RST;
        end else if (wrCommit && wrIdx == DIR_IDX[WA-1:0]) begin
            portFDirection <= laneMerge(portFDirection, wrData, wrStrb);
        end else if (wrCommit && wrIdx == CTRL_IDX[WA-1:0]) begin
            portFControl <= laneMerge(portFControl, wrData, wrStrb) & 16'h007F;
        end
    end

    // Read channel with the same four-cycle latency
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdState <= GPF_BUS_IDLE;
            rdCnt <= 3'h0;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `GPF_RESP_OKAY;
            rdIdx <= '0;
        end else begin
            unique case (rdState)
                GPF_BUS_IDLE: begin
                    arready <= 1'b1;
                    if (arvalid && arready) begin
                        arready <= 1'b0;
                        rdIdx <= araddr[ADDR_W-1:2];
                        rdState <= GPF_BUS_WAIT;
                        rdCnt <= 3'h0;
                    end
                end
                GPF_BUS_WAIT: begin
                    rdCnt <= rdCnt + 3'h1;
                    if (rdCnt == `GPF_ACCESS_CYCLES - 3'h2) begin
                        rdState <= GPF_BUS_RESP;
                        rvalid <= 1'b1;
                        rresp <= `GPF_RESP_OKAY;
                        if (rdIdx == DATA_IDX[WA-1:0]) begin
                            rdata <= {16'h0000, readView};
                        end else if (rdIdx == DIR_IDX[WA-1:0]) begin
                            rdata <= {16'h0000, portFDirection};
                        end else if (rdIdx == CTRL_IDX[WA-1:0]) begin
                            rdata <= {16'h0000, portFControl};
                        end else if (rdIdx == STAT_IDX[WA-1:0]) begin
                            rdata <= {12'h000, modeLocked, opMode, pinSync};
                        end else begin
                            rdata <= 32'h00000000;
                            rresp <= `GPF_RESP_SLVERR;
                        end
                    end
                end
                GPF_BUS_RESP: begin
                    if (rready) begin
                        rdState <= GPF_BUS_IDLE;
                        rvalid <= 1'b0;
                    end
                end
            endcase
        end
    end
endmodule

// ---- verification/gpf_checker.sv ----
`timescale 1ns/10ps
// Bus timing and pin roles at the port
module gpf_checker (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic busAck,
    input wire logic chipSelect0,
    input wire logic chipSelect1,
    input wire logic chipSelect2,
    input wire logic chipSelect3,
    input wire logic readStrobe,
    input wire logic writeStrobeHigh,
    input wire logic writeStrobeLow,
    input wire logic [21:16] extAddr,
    input wire logic busRequestIn,
    input wire logic waitIn,
    input wire logic outputDisableN,
    input wire logic [15:0] pinOut,
    input wire logic [15:0] pinOeN,
    input wire gpf_pkg::gpf_mode_t opMode
);
    import gpf_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    // Answers four edges after the request is taken
    property p_wrLat;
        awvalid && awready && wvalid && wready |=> !bvalid [*3] ##1 bvalid;
    endproperty
    a_wrLat: assert property (p_wrLat) else $error("write answer off time");
    property p_rdLat;
        arvalid && arready |=> !rvalid [*3] ##1 rvalid;
    endproperty
    a_rdLat: assert property (p_rdLat) else $error("read answer off time");
    property p_bHold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_bHold: assert property (p_bHold) else $error("write answer dropped");
    property p_rHold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_rHold: assert property (p_rHold) else $error("read answer dropped");
    // Two cycles of disable low cover either pipeline depth
    property p_podLow;
        (opMode == GPF_MODE_SINGLE && !outputDisableN) [*2] |-> (&pinOeN[4:0]);
    endproperty
    a_podLow: assert property (p_podLow) else $error("low pins drive while disabled");
    property p_romDis;
        opMode == GPF_MODE_ROM_DIS && $past(opMode) == GPF_MODE_ROM_DIS
            |=> pinOeN[5:0] == 6'h00 && pinOut[5:0] == $past(extAddr);
    endproperty
    a_romDis: assert property (p_romDis) else $error("address pins wrong");
    property p_romEnOut;
        opMode == GPF_MODE_ROM_EN && $past(opMode) == GPF_MODE_ROM_EN
            |=> pinOut[14:9] == $past({busAck, chipSelect3, chipSelect2, chipSelect1,
            chipSelect0, readStrobe}) && pinOut[7:6] == $past({writeStrobeHigh, writeStrobeLow});
    endproperty
    a_romEnOut: assert property (p_romEnOut) else $error("bus strobe pins wrong");
    property p_romEnIn;
        opMode == GPF_MODE_ROM_EN |-> pinOeN[15] && pinOeN[8];
    endproperty
    a_romEnIn: assert property (p_romEnIn) else $error("bus input pin driven");
    property p_otherIn;
        opMode != GPF_MODE_ROM_EN |-> !busRequestIn && !waitIn;
    endproperty
    a_otherIn: assert property (p_otherIn) else $error("bus inputs live off mode");
    c_wr: cover property (bvalid && bready);
    c_pod: cover property (!outputDisableN);
    c_romEn: cover property (opMode == GPF_MODE_ROM_EN && busRequestIn);
endmodule

// ---- verification/gpf_board.sv ----
`timescale 1ns/10ps
// Board side of the sixteen pins
module gpf_board (
    input wire logic sys_clk,
    input wire logic [15:0] pinOut,
    input wire logic [15:0] pinOeN,
    input wire logic [15:0] extDrive,
    input wire logic [15:0] extLevel,
    output logic [15:0] pinIn
);
    logic [15:0] lastLevel = 16'h0000;
    // Port drive wins; an undriven line flips each cycle
    assign pinIn = (~pinOeN & pinOut) | (pinOeN & extDrive & extLevel) |
        (pinOeN & ~extDrive & ~lastLevel);
    always @(posedge sys_clk) begin
        lastLevel <= pinIn;
    end
endmodule

// ---- verification/test_gpf_port_f_data.sv ----
`timescale 1ns/10ps
`include "gpf_defines.svh"
// Self-checking bench for the port F data path
module test_gpf_port_f_data;
    import gpf_pkg::*;
    localparam logic [11:0] A_DATA = 12'(`GPF_DATA_IDX << 2);
    localparam logic [11:0] A_DIR = 12'(`GPF_DIR_IDX << 2);
    localparam logic [11:0] A_CTRL = 12'(`GPF_CTRL_IDX << 2);
    localparam logic [11:0] A_STAT = 12'(`GPF_STAT_IDX << 2);
    localparam logic [11:0] A_BAD = 12'h100;
    localparam logic [1:0] OK = `GPF_RESP_OKAY;
    localparam logic [1:0] BAD = `GPF_RESP_SLVERR;
    logic sys_clk = 1'b0, resetn = 1'b0, wdtReset = 1'b0, hwStandby = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic busAck = 1'b0, chipSelect0 = 1'b0, chipSelect1 = 1'b0, chipSelect2 = 1'b0;
    logic chipSelect3 = 1'b0, readStrobe = 1'b0, writeStrobeHigh = 1'b0, writeStrobeLow = 1'b0;
    logic [1:0] modePins = 2'h2;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic [21:16] extAddr = 6'h00;
    logic [15:0] extDrive = 16'h0000, extLevel = 16'h0000;
    logic awready, wready, bvalid, arready, rvalid, busRequestIn, waitIn, outputDisableN;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] pinIn, pinOut, pinOeN;
    gpf_mode_t opMode;
    int failCount = 0, comparisons = 0, cycles = 0;

    gpf_port u_gpf_port (.sys_clk, .resetn, .wdtReset, .modePins, .hwStandby, .awaddr,
        .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .busAck, .chipSelect0, .chipSelect1, .chipSelect2, .chipSelect3, .readStrobe,
        .writeStrobeHigh, .writeStrobeLow, .extAddr, .busRequestIn, .waitIn, .outputDisableN,
        .pinIn, .pinOut, .pinOeN, .opMode);
    gpf_board u_gpf_board (.sys_clk, .pinOut, .pinOeN, .extDrive, .extLevel, .pinIn);

    always #2.5 sys_clk = ~sys_clk;
    // Ceiling far above the run; a hung handshake ends it
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failCount++;
            summarize();
        end
    end
    task automatic summarize();
        $display("Counts: %0d mismatches, %0d comparisons", failCount, comparisons);
        if (failCount == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failCount++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Both halves offered together; each valid drops once its own ready is seen
    task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s,
        input logic [1:0] er);
        awaddr <= a;
        wdata <= {16'h0000, d};
        wstrb <= s;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        do @(posedge sys_clk); while (bvalid !== 1'b1);
        chk(32'(bresp), 32'(er));
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge sys_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge sys_clk); while (rvalid !== 1'b1);
        d = rdata;
        chk(32'(rresp), 32'(er));
        rready <= 1'b0;
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d, OK);
        chk(d, e);
    endtask
    task automatic boot(input logic [1:0] m);
        resetn <= 1'b0;
        modePins <= m;
        cyc(12);
        resetn <= 1'b1;
        cyc(8);
    endtask
    // Cleared state, reported mode and a refused address
    task automatic tReset();
        logic [31:0] d;
        rc(A_DATA, 32'h0);
        rc(A_DIR, 32'h0);
        rd(A_STAT, d, OK);
        chk(32'(d[19:16]), 32'hC);
        rd(A_BAD, d, BAD);
        chk(d, 32'h0);
        wr(A_BAD, 16'hFFFF, 4'h3, BAD);
    endtask
    // Outputs, byte lanes, then the upper byte turned to inputs
    task automatic tOutIn();
        wr(A_DIR, 16'hFFFF, 4'h3, OK);
        wr(A_DATA, 16'hA5C3, 4'h3, OK);
        cyc(2);
        chk(32'(pinOut), 32'hA5C3);
        chk(32'(pinOeN), 32'h0);
        rc(A_DATA, 32'hA5C3);
        wr(A_DATA, 16'h005A, 4'h1, OK);
        wr(A_DATA, 16'h3C00, 4'h2, OK);
        rc(A_DATA, 32'h3C5A);
        extDrive <= 16'hFF00;
        extLevel <= 16'h9600;
        wr(A_DIR, 16'h00FF, 4'h3, OK);
        cyc(8);
        rc(A_DATA, 32'h965A);
        wr(A_DATA, 16'h0F5A, 4'h3, OK);
        cyc(2);
        chk(32'(pinOeN), 32'hFF00);
        rc(A_DATA, 32'h965A);
        extDrive <= 16'h0000;
        wr(A_DIR, 16'hFFFF, 4'h3, OK);
        cyc(2);
        chk(32'(pinOut), 32'h0F5A);
    endtask
    // Pin 5 as disable input gates only pins 0 to 4
    task automatic tPod();
        wr(A_CTRL, 16'h0040, 4'h3, OK);
        extDrive <= 16'h0020;
        wr(A_DIR, 16'hFFDF, 4'h3, OK);
        cyc(8);
        chk(32'(outputDisableN), 32'h0);
        chk(32'(pinOeN), 32'h003F);
        extLevel <= 16'h0020;
        cyc(8);
        chk(32'(pinOeN), 32'h0020);
        chk(32'(pinOut[4:0]), 32'h1A);
    endtask
    // Watchdog keeps the data, hardware standby clears it
    task automatic tRetain();
        wdtReset <= 1'b1;
        cyc(1);
        wdtReset <= 1'b0;
        cyc(2);
        rc(A_DIR, 32'h0);
        wr(A_DIR, 16'hFFFF, 4'h3, OK);
        rc(A_DATA, 32'h0F5A);
        hwStandby <= 1'b1;
        cyc(10);
        hwStandby <= 1'b0;
        cyc(8);
        wr(A_DIR, 16'hFFFF, 4'h3, OK);
        rc(A_DATA, 32'h0);
    endtask
    // Expansion with ROM: strobes out, request and wait in, address on the low pins
    task automatic tRomEn();
        extDrive <= 16'h8100;
        extLevel <= 16'h8000;
        busAck <= 1'b1;
        chipSelect3 <= 1'b1;
        chipSelect1 <= 1'b1;
        writeStrobeHigh <= 1'b1;
        extAddr <= 6'h2D;
        boot(2'h1);
        wr(A_CTRL, 16'h003F, 4'h3, OK);
        cyc(2);
        chk(32'(pinOeN), 32'h8100);
        chk(32'({pinOut[14:9], pinOut[7:0]}), 32'h34AD);
        chk(32'({busRequestIn, waitIn}), 32'h2);
        wr(A_DIR, 16'hFFFF, 4'h3, OK);
        wr(A_DATA, 16'h1234, 4'h3, OK);
        cyc(2);
        rc(A_DATA, 32'h1234);
        chk(32'(pinOut[14:9]), 32'h34);
        wr(A_DIR, 16'h0000, 4'h3, OK);
        cyc(6);
        rc(A_DATA, 32'hE8AD);
    endtask
    // Expansion without ROM: low six pins fixed to the address
    task automatic tRomDis();
        extDrive <= 16'h0000;
        extAddr <= 6'h15;
        boot(2'h0);
        chk(32'(pinOeN[5:0]), 32'h0);
        wr(A_DIR, 16'hFFFF, 4'h3, OK);
        wr(A_DATA, 16'h803F, 4'h3, OK);
        cyc(2);
        chk(32'(pinOut), 32'h8015);
        chk(32'(pinOeN), 32'h0);
    endtask
    initial begin
        boot(2'h2);
        tReset();
        tOutIn();
        tPod();
        tRetain();
        tRomEn();
        tRomDis();
        summarize();
    end
endmodule

bind gpf_port gpf_checker u_gpf_checker (.sys_clk, .resetn, .awvalid,
    .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid,
    .rready, .busAck, .chipSelect0, .chipSelect1, .chipSelect2, .chipSelect3, .readStrobe,
    .writeStrobeHigh, .writeStrobeLow, .extAddr, .busRequestIn, .waitIn, .outputDisableN,
    .pinOut, .pinOeN, .opMode);
